/* design/csc_regs.svh */
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
// ==========================================================
// Register byte offsets
`define CSC_LOGIC_SEL_OFF 8'h7C
`define CSC_CTRL_OFF      8'hA0
`define CSC_AUX_OFF       8'hA4
`define CSC_STAT_OFF      8'hA8
// ==========================================================
// Reset values
`define CSC_LOGIC_SEL_RST 8'h00
`define CSC_CTRL_RST      8'h00
`define CSC_AUX_RST       8'h00
// ==========================================================
// Control register fields
`define CSC_EN_BIT        0
`define CSC_MODE_LSB      1
`define CSC_MODE_MSB      2
`define CSC_DS_BIT        3
`define CSC_CCLK_BIT      4
`define CSC_SWCLK_BIT     5
`define CSC_OUT_LSB       6
`define CSC_OUT_MSB       7
// Logic-select and auxiliary fields
`define CSC_FN0_LSB       0
`define CSC_FN0_MSB       3
`define CSC_FN1_LSB       4
`define CSC_FN1_MSB       7
`define CSC_CASC_BIT      0
`define CSC_DSEL0_BIT     1
// ==========================================================
// Timing and bus answers
`define CSC_PRESCALE_DEF  4
`define CSC_RESP_OKAY     2'h0
`define CSC_RESP_SLVERR   2'h2
`endif

/* design/csc_pkg.sv */
package csc_pkg;
    typedef enum logic [1:0] {
        CSC_MODE_EVENT  = 2'h0,
        CSC_MODE_PULSE  = 2'h1,
        CSC_MODE_PERIOD = 2'h2,
        CSC_MODE_CONT   = 2'h3
    } csc_mode_type;
    typedef enum logic [3:0] {
        CSC_ST_IDLE  = 4'h1,
        CSC_ST_ARMED = 4'h2,
        CSC_ST_RUN   = 4'h4,
        CSC_ST_DONE  = 4'h8
    } csc_state_type;
    typedef enum logic [1:0] {
        CSC_OUT_INPUT = 2'h0,
        CSC_OUT_IRQ   = 2'h1,
        CSC_OUT_LOW   = 2'h2,
        CSC_OUT_HIGH  = 2'h3
    } csc_outsel_type;
endpackage

/* design/csc_cnt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface csc_cnt_if import csc_pkg::*; ();
    logic         enable;
    logic         ds_mode;
    logic         tick;
    logic         level;
    logic         irq_evt;
    logic         cascade;
    csc_mode_type mode;
    logic [15:0]  count;
    logic         running;
    logic         done;
    modport ctrl (output enable, ds_mode, tick, level, irq_evt, cascade, mode,
                  input count, running, done);
    modport cnt  (input enable, ds_mode, tick, level, irq_evt, cascade, mode,
                  output count, running, done);
endinterface
`default_nettype wire

/* design/csc_lut.sv */
`timescale 1ns/10ps
`default_nettype none
module csc_lut (
    // Comparator inputs
    input  wire logic       in_a,
    input  wire logic       in_b,
    // Function code
    input  wire logic [3:0] fn,
    // Result
    output logic            y
);
    // ==========================================================
    // Truth table: code bit indexed by inverted inputs
    function automatic logic csc_lut_eval(input logic [3:0] f, input logic a, input logic b);
        logic [1:0] idx;
        idx = {~a, ~b};
        return f[idx];
    endfunction

    // 0h low, Fh high, 3h A, 5h B, 6h-9h XOR/OR/NOR/XNOR, 1h AND, rest inverted forms
    assign y = csc_lut_eval(fn, in_a, in_b);
endmodule
`default_nettype wire

/* design/csc_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module csc_counter import csc_pkg::*; (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Control and results
    csc_cnt_if.cnt    bus
);
    csc_state_type state_r, state_nxt;
    logic [7:0]    lo_r, lo_nxt;
    logic [7:0]    hi_r, hi_nxt;
    logic          prev_r, prev_nxt;
    logic          rise, fall, stop, step;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        lo_nxt    = lo_r;
        hi_nxt    = hi_r;
        prev_nxt  = bus.level;
        rise      = bus.level & ~prev_r;
        fall      = ~bus.level & prev_r;
        stop      = ((bus.mode == CSC_MODE_EVENT) & bus.irq_evt) |
                    ((bus.mode == CSC_MODE_PULSE) & fall) |
                    ((bus.mode == CSC_MODE_PERIOD) & rise);
        // Counters only toggle in delta-sigma mode
        step      = (state_r == CSC_ST_RUN) & bus.ds_mode & bus.tick;
        if (!bus.enable) begin
            state_nxt = CSC_ST_IDLE;
            lo_nxt    = 8'h00;
            hi_nxt    = 8'h00;
        end else begin
            case (state_r)
                CSC_ST_IDLE: begin
                    // Event and continuous start at enable, edge modes arm
                    if (bus.mode == CSC_MODE_EVENT || bus.mode == CSC_MODE_CONT) begin
                        state_nxt = CSC_ST_RUN;
                    end else begin
                        state_nxt = CSC_ST_ARMED;
                    end
                end
                CSC_ST_ARMED: begin
                    if (rise) begin
                        state_nxt = CSC_ST_RUN;
                    end
                end
                CSC_ST_RUN: begin
                    if (stop) begin
                        state_nxt = CSC_ST_DONE;
                    end
                end
                CSC_ST_DONE: state_nxt = CSC_ST_DONE;
                default:     state_nxt = CSC_ST_IDLE;
            endcase
            if (step) begin
                if (bus.cascade) begin
                    {hi_nxt, lo_nxt} = 16'({hi_r, lo_r} + 16'h0001);
                end else begin
                    lo_nxt = 8'(lo_r + 8'h01);
                    hi_nxt = 8'(hi_r + 8'h01);
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= CSC_ST_IDLE;
            lo_r    <= 8'h00;
            hi_r    <= 8'h00;
            prev_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            lo_r    <= lo_nxt;
            hi_r    <= hi_nxt;
            prev_r  <= prev_nxt;
        end
    end

    assign bus.count   = {hi_r, lo_r};
    assign bus.running = (state_r == CSC_ST_RUN);
    assign bus.done    = (state_r == CSC_ST_DONE);

    // ==========================================================
    // Checks
    a_disable_clears: assert property (@(posedge clock) disable iff (!nrst)
        !bus.enable |=> (bus.count == 16'h0000) && !bus.running)
        else $error("counters not cleared after disable");
    a_no_ds_hold: assert property (@(posedge clock) disable iff (!nrst)
        (bus.enable && !bus.ds_mode) |=> $stable(bus.count))
        else $error("counter moved without delta-sigma mode");
    a_cont_counts: assert property (@(posedge clock) disable iff (!nrst)
        (bus.enable && bus.running && bus.mode == CSC_MODE_CONT && bus.ds_mode
         && bus.tick && !bus.cascade) |=> (lo_r == 8'($past(lo_r) + 8'h01)) && bus.running)
        else $error("continuous mode did not count");
    a_cascade_carry: assert property (@(posedge clock) disable iff (!nrst)
        (bus.enable && step && bus.cascade && lo_r == 8'hFF)
        |=> (lo_r == 8'h00) && (hi_r == 8'($past(hi_r) + 8'h01)))
        else $error("cascade carry lost");
    a_period_stop: assert property (@(posedge clock) disable iff (!nrst)
        (bus.enable && bus.running && bus.mode == CSC_MODE_PERIOD && rise) |=> bus.done)
        else $error("period mode did not stop on rising edge");
endmodule
`default_nettype wire

/* design/csc_top.sv */
// Function
// - Comp0 data select routes logic output (0) or latch output (1) onward.
// - Bits 7:4 pick bus 1 function; A is comp1, B is comp0.
// - Bits 3:0 pick bus 0 function; A is comp0, B is comp1.
// - Codes 6h..9h give XOR, OR, NOR, XNOR.
// - Code 3h passes A, code 5h passes B.
// - Code 0h forces low, code Fh forces high.
// - Output select drives input, sense interrupt, low or high counter output.
// - Switch clock from prescaled oscillator (0) or pseudo-random sequence (1).
// - Counter clock from main oscillator (0) or prescaled oscillator (1).
// - Delta-sigma mode moves timer one to prescaled clock, lets counters toggle.
// - Prescaled clock runs freely from reset, whether or not delta-sigma mode is set.
// - Event mode starts at enable, stops at interrupt event.
// - Pulse width mode runs from next rising to following falling edge.
// - Period mode runs from a rising edge to the next rising edge.
// - Continuous mode runs from enable until disable.
// - Clearing enable stops and zeroes counters; setting it enables counting.
// - Cascade joins high and low counters into one 16-bit counter.
`include "csc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module csc_top import csc_pkg::*; #(
    parameter int ADDR_W   = 8,
    parameter int PRESCALE = `CSC_PRESCALE_DEF
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Analog side
    input  wire logic              comp0_out,
    input  wire logic              comp1_out,
    input  wire logic              comp0_latch,
    input  wire logic              sense_irq_event,
    // Clock sources
    input  wire logic              pseudo_random_seq,
    input  wire logic              slow_32k_tick,
    input  wire logic              timer_clk_sel,
    // Outputs
    output logic                   comp_bus0,
    output logic                   comp_bus1,
    output logic                   comp0_channel,
    output logic                   sense_output,
    output logic                   switch_clock_en,
    output logic                   timer_one_clock_en
);
    // Refused at elaboration: decode needs 8 address bits, prescaler at least 2
    if (ADDR_W < 8 || ADDR_W > 32 || PRESCALE < 2 || PRESCALE > 256) begin : g_bad_param
        $error("csc_top: unsupported ADDR_W or PRESCALE");
    end


    // ==========================================================
    // Address decode, one-hot {status, aux, control, logic select}
    function automatic logic [3:0] csc_decode(input logic [ADDR_W-1:0] a);
        csc_decode = {a == ADDR_W'(`CSC_STAT_OFF), a == ADDR_W'(`CSC_AUX_OFF),
                      a == ADDR_W'(`CSC_CTRL_OFF), a == ADDR_W'(`CSC_LOGIC_SEL_OFF)};
    endfunction

    csc_cnt_if cnt_if ();

    logic              aw_hold_r, aw_hold_nxt;
    logic              w_hold_r, w_hold_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [7:0]        wbyte_r, wbyte_nxt;
    logic              wlane_r, wlane_nxt;
    logic              awready_r, awready_nxt;
    logic              wready_r, wready_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              arready_r, arready_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic [7:0]        lsel_r, lsel_nxt;
    logic [7:0]        ctrl_r, ctrl_nxt;
    logic [7:0]        aux_r, aux_nxt;
    logic [3:0]        whit, rhit;

    // ==========================================================
    // Bus slave and register file
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        awaddr_nxt  = awaddr_r;
        wbyte_nxt   = wbyte_r;
        wlane_nxt   = wlane_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        lsel_nxt    = lsel_r;
        ctrl_nxt    = ctrl_r;
        aux_nxt     = aux_r;
        whit        = csc_decode(awaddr_r);
        rhit        = csc_decode(s_axi_araddr);
        if (s_axi_awvalid && awready_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_hold_nxt = 1'b1;
            wbyte_nxt  = s_axi_wdata[7:0];
            wlane_nxt  = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_hold_r && w_hold_r && !bvalid_r) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = (whit == 4'h0) ? `CSC_RESP_SLVERR : `CSC_RESP_OKAY;
            if (wlane_r) begin
                if (whit[0]) begin
                    lsel_nxt = wbyte_r;
                end
                // Mode and selects are used live; software keeps them still while enabled
                if (whit[1]) begin
                    ctrl_nxt = wbyte_r;
                end
                if (whit[2]) begin
                    aux_nxt = {6'h00, wbyte_r[1:0]};
                end
            end
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = (rhit == 4'h0) ? `CSC_RESP_SLVERR : `CSC_RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            case (1'b1)
                rhit[0]: rdata_nxt = {24'h00_0000, lsel_r};
                rhit[1]: rdata_nxt = {24'h00_0000, ctrl_r};
                rhit[2]: rdata_nxt = {24'h00_0000, aux_r};
                rhit[3]: rdata_nxt = {14'h0000, cnt_if.done, cnt_if.running, cnt_if.count};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        awready_nxt = !aw_hold_nxt;
        wready_nxt  = !w_hold_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wbyte_r   <= 8'h00;
            wlane_r   <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CSC_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `CSC_RESP_OKAY;
            lsel_r    <= `CSC_LOGIC_SEL_RST;
            ctrl_r    <= `CSC_CTRL_RST;
            aux_r     <= `CSC_AUX_RST;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awaddr_r  <= awaddr_nxt;
            wbyte_r   <= wbyte_nxt;
            wlane_r   <= wlane_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            lsel_r    <= lsel_nxt;
            ctrl_r    <= ctrl_nxt;
            aux_r     <= aux_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ==========================================================
    // Comparator logic functions
    logic bus0_y, bus1_y, chan0;

    csc_lut u_fn0 (
        .in_a (comp0_out),
        .in_b (comp1_out),
        .fn   (lsel_r[`CSC_FN0_MSB:`CSC_FN0_LSB]),
        .y    (bus0_y)
    );
    csc_lut u_fn1 (
        .in_a (comp1_out),
        .in_b (comp0_out),
        .fn   (lsel_r[`CSC_FN1_MSB:`CSC_FN1_LSB]),
        .y    (bus1_y)
    );

    assign chan0 = aux_r[`CSC_DSEL0_BIT] ? comp0_latch : bus0_y;

    // ==========================================================
    // Clocking and counter control
    localparam int PW = $clog2(PRESCALE);

    logic [PW-1:0] presc_r, presc_nxt;
    logic          presc_tick;
    logic          bus0_r, bus1_r, chan0_r, sout_r, swclk_r, t1clk_r;
    logic          sout_nxt, swclk_nxt, t1clk_nxt;

    // Prescaler never stops, so its phase stays free-running from reset on
    assign presc_tick = (presc_r == PW'(PRESCALE - 1));

    assign cnt_if.enable  = ctrl_r[`CSC_EN_BIT];
    assign cnt_if.mode    = csc_mode_type'(ctrl_r[`CSC_MODE_MSB:`CSC_MODE_LSB]);
    assign cnt_if.ds_mode = ctrl_r[`CSC_DS_BIT];
    assign cnt_if.tick    = ctrl_r[`CSC_CCLK_BIT] ? presc_tick : 1'b1;
    assign cnt_if.level   = chan0;
    assign cnt_if.irq_evt = sense_irq_event;
    assign cnt_if.cascade = aux_r[`CSC_CASC_BIT];

    csc_counter u_counter (
        .clock (clock),
        .nrst  (nrst),
        .bus   (cnt_if)
    );

    always_comb begin
        presc_nxt = presc_tick ? '0 : PW'(presc_r + PW'(1));
        case (csc_outsel_type'(ctrl_r[`CSC_OUT_MSB:`CSC_OUT_LSB]))
            CSC_OUT_INPUT: sout_nxt = chan0;
            CSC_OUT_IRQ:   sout_nxt = sense_irq_event;
            CSC_OUT_LOW:   sout_nxt = cnt_if.count[7];
            CSC_OUT_HIGH:  sout_nxt = cnt_if.count[15];
            default:       sout_nxt = 1'b0;
        endcase
        swclk_nxt = ctrl_r[`CSC_SWCLK_BIT] ? pseudo_random_seq : presc_tick;
        if (ctrl_r[`CSC_DS_BIT]) begin
            t1clk_nxt = presc_tick;
        end else begin
            t1clk_nxt = timer_clk_sel ? slow_32k_tick : 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            presc_r <= '0;
            bus0_r  <= 1'b0;
            bus1_r  <= 1'b0;
            chan0_r <= 1'b0;
            sout_r  <= 1'b0;
            swclk_r <= 1'b0;
            t1clk_r <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            bus0_r  <= bus0_y;
            bus1_r  <= bus1_y;
            chan0_r <= chan0;
            sout_r  <= sout_nxt;
            swclk_r <= swclk_nxt;
            t1clk_r <= t1clk_nxt;
        end
    end

    assign comp_bus0          = bus0_r;
    assign comp_bus1          = bus1_r;
    assign comp0_channel      = chan0_r;
    assign sense_output       = sout_r;
    assign switch_clock_en    = swclk_r;
    assign timer_one_clock_en = t1clk_r;

    // ==========================================================
    // Checks
    a_bus0_xor: assert property (@(posedge clock) disable iff (!nrst)
        (lsel_r[3:0] == 4'h6) |=> (comp_bus0 == ($past(comp0_out) ^ $past(comp1_out))))
        else $error("bus 0 xor wrong");
    a_bus1_pass_b: assert property (@(posedge clock) disable iff (!nrst)
        (lsel_r[7:4] == 4'h5) |=> (comp_bus1 == $past(comp0_out)))
        else $error("bus 1 pass B wrong");
    a_swclk_prs: assert property (@(posedge clock) disable iff (!nrst)
        ctrl_r[5] |=> (switch_clock_en == $past(pseudo_random_seq)))
        else $error("switch clock source wrong");
    a_sense_out_irq: assert property (@(posedge clock) disable iff (!nrst)
        (ctrl_r[7:6] == 2'h1) |=> (sense_output == $past(sense_irq_event)))
        else $error("sense output not interrupt");
endmodule
`default_nettype wire

/* tb/csc_analog.sv */
`timescale 1ns/10ps
`default_nettype none
module csc_analog (
    // Clock, reset and requested levels
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [3:0] lvl,
    // Comparator and clock source outputs
    output logic            comp0_out,
    output logic            comp1_out,
    output logic            comp0_latch,
    output logic            sense_irq_event,
    output logic            pseudo_random_seq,
    output logic            slow_32k_tick
);
    logic [3:0] lfsr;
    logic [2:0] div;
    // Comparators settle to the system clock, so levels change only at edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {comp0_out, comp1_out, comp0_latch, sense_irq_event} <= 4'h0;
            lfsr <= 4'h1;
            div <= 3'h0;
        end else begin
            {comp0_out, comp1_out, comp0_latch, sense_irq_event} <= lvl;
            lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            div <= div + 3'h1;
        end
    end
    assign pseudo_random_seq = lfsr[0];
    assign slow_32k_tick     = (div == 3'h7);
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, c0, c1, lat, irq, prnd, s32, tsel, bus0, bus1, chan, sout, swc, t1c;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, s1, s2;
    logic [3:0]  wstrb, lvl;
    logic [1:0]  bresp, rresp, r;
    int          miscompares, num_checks;
    csc_top i_csc_top (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp0_out(c0), .comp1_out(c1), .comp0_latch(lat),
        .sense_irq_event(irq), .pseudo_random_seq(prnd), .slow_32k_tick(s32),
        .timer_clk_sel(tsel), .comp_bus0(bus0), .comp_bus1(bus1), .comp0_channel(chan),
        .sense_output(sout), .switch_clock_en(swc), .timer_one_clock_en(t1c));
    csc_analog i_csc_analog (.clock(clock), .nrst(nrst), .lvl(lvl), .comp0_out(c0),
        .comp1_out(c1), .comp0_latch(lat), .sense_irq_event(irq),
        .pseudo_random_seq(prnd), .slow_32k_tick(s32));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    // Both channels offered together; each dropped only after its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw;
        r = 2'h3;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 64 && r === 2'h3; n++) begin
            @(negedge clock);
            ta = awvalid & (awready === 1'b1);
            tw = wvalid & (wready === 1'b1);
            if (bvalid === 1'b1) r = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        if (r === 2'h3) begin miscompares++; summarize(); end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ta;
        r = 2'h3;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 64 && r === 2'h3; n++) begin
            @(negedge clock);
            ta = arvalid & (arready === 1'b1);
            if (rvalid === 1'b1) begin d = rdata; r = rresp; end
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
        end
        if (r === 2'h3) begin miscompares++; summarize(); end
    endtask
    task automatic t_regs();
        rd(8'h7C, s1); chk("lut_rst", 32'h0, s1);
        rd(8'hA0, s1); chk("ctrl_rst", 32'h0, s1);
        rd(8'h10, s1); chk("unm_rresp", 2'h2, r);
        wr(8'h10, 8'hFF); chk("unm_bresp", 2'h2, r);
        $display("t_regs done");
    endtask
    task automatic t_lut();
        for (int c = 0; c < 16; c++) begin
            wr(8'h7C, {c[3:0], c[3:0]});
            for (int ab = 0; ab < 4; ab++) begin
                lvl <= {ab[1:0], 2'h0};
                repeat (4) @(posedge clock);
                chk("bus0", c[{~ab[1], ~ab[0]}], bus0);
                chk("bus1", c[{~ab[0], ~ab[1]}], bus1);
            end
        end
        rd(8'h7C, s1); chk("lut_rb", 32'hFF, s1);
        $display("t_lut done");
    endtask
    task automatic t_sel();
        wr(8'h7C, 8'h00); wr(8'hA4, 8'h02); lvl <= 4'h2;
        repeat (4) @(posedge clock);
        chk("chan_latch", 1, chan);
        chk("out_in", 1, sout);
        wr(8'hA0, 8'h40); lvl <= 4'h1;
        repeat (4) @(posedge clock);
        chk("out_irq", 1, sout);
        wr(8'hA4, 8'h00); lvl <= 4'h2;
        repeat (4) @(posedge clock);
        chk("chan_lut", 0, chan);
        chk("out_irq0", 0, sout);
        wr(8'hA0, 8'h00);
        $display("t_sel done");
    endtask
    // Pulse and period bounds allow two cycles of edge-detect slack; event and continuous bounds are wide
    task automatic t_cnt(input logic [1:0] m, input int lo, input int hi);
        wr(8'h7C, 8'h03); wr(8'hA4, 8'h01);
        wr(8'hA0, {5'h01, m, 1'b1});
        case (m)
            2'h0: begin repeat (20) @(posedge clock); lvl <= 4'h1; @(posedge clock); end
            2'h1: begin repeat (5) @(posedge clock); lvl <= 4'h8; repeat (30) @(posedge clock); end
            2'h2: begin lvl <= 4'h8; repeat (10) @(posedge clock); lvl <= 4'h0;
                repeat (10) @(posedge clock); lvl <= 4'h8; repeat (10) @(posedge clock); end
            default: repeat (260) @(posedge clock);
        endcase
        lvl <= 4'h0;
        repeat (6) @(posedge clock);
        rd(8'hA8, s1); repeat (10) @(posedge clock); rd(8'hA8, s2);
        chk("running", m == 2'h3, s2[16]);
        chk("done", m != 2'h3, s2[17]);
        chk("cnt_range", 1, s1[15:0] >= lo && s1[15:0] <= hi);
        chk("cnt_moves", m == 2'h3, s2[15:0] != s1[15:0]);
        wr(8'hA0, {5'h01, m, 1'b0});
        rd(8'hA8, s1); chk("cnt_clear", 32'h0, s1);
        $display("t_cnt mode %0d done", m);
    endtask
    // Clock sources: delta-sigma off, then on with prescaled sources
    task automatic t_clk();
        logic p;
        int n, m;
        wr(8'hA4, 8'h00); wr(8'hA0, 8'hF7);
        @(negedge clock); p = prnd; n = 0;
        repeat (16) begin
            @(negedge clock); chk("swclk_prs", p, swc);
            p = prnd; n += t1c;
        end
        @(posedge clock); chk("t1clk_cpu", 16, n);
        rd(8'hA8, s1); chk("cnt_no_ds", 32'h1_0000, s1);
        tsel <= 1'b1; @(posedge clock); n = 0;
        repeat (16) begin @(negedge clock); n += t1c; end
        @(posedge clock); chk("t1clk_32k", 2, n);
        wr(8'hA0, 8'hF6); wr(8'hA0, 8'hDF); n = 0; m = 0;
        repeat (16) begin @(negedge clock); n += t1c; m += swc; end
        @(posedge clock); chk("t1clk_presc", 4, n);
        chk("swclk_presc", 4, m);
        rd(8'hA8, s1); repeat (14) @(posedge clock); rd(8'hA8, s2);
        chk("cnt_presc", 4, 8'(s2[7:0] - s1[7:0]));
        chk("cnt_split", 1, s2[15:8] == s2[7:0]);
        wr(8'hA0, 8'hDE);
        $display("t_clk done");
    endtask
    initial begin
        miscompares = 0; num_checks = 0; nrst = 1'b0; lvl = 4'h0; tsel = 1'b0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
        awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'hF;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        t_regs();
        t_lut();
        t_sel();
        t_cnt(2'h0, 10, 60);
        t_cnt(2'h1, 28, 32);
        t_cnt(2'h2, 18, 22);
        t_cnt(2'h3, 256, 600);
        t_clk();
        summarize();
    end
endmodule
`default_nettype wire
